/* File: core/slp_pkg.sv */
// constants, types and helpers shared by the status led indicator block
//
// Overview of operation
// - network led steady on while unregistered
// - network led blinks 2 Hz once registered
// - session led on only when apn attached
// - cellular tx led pulses per sent frame/message
// - cellular rx led pulses per received frame/message
// - text mode samples level at registration, every 12min
// - packet mode samples level only at registration
// - while unregistered, periodically reset modem and retry
// - port tx/rx leds show secondary port traffic
// - slave mode forwards queries for foreign station only
// - transparent mode passes packet data to port
// - navigation receive mode never pulses port tx led
package slp_pkg;

  // timing figures in their own units
  localparam longint unsigned SLP_CLK_HZ     = 64'd100000000; // system clock
  localparam longint unsigned SLP_BLINK_HZ   = 64'd2;         // registered blink rate
  localparam longint unsigned SLP_SGN_MIN    = 64'd12;        // text mode level refresh
  localparam longint unsigned SLP_STRETCH_MS = 64'd50;        // visible flash length
  localparam longint unsigned SLP_RETRY_S    = 64'd60;        // registration give-up time

  // derived cycle counts; blink toggles twice per period
  localparam int              SLP_CW         = 40;
  localparam logic [39:0]     SLP_BLINK_CYC  = 40'(SLP_CLK_HZ / (64'd2 * SLP_BLINK_HZ));
  localparam logic [39:0]     SLP_SGN_CYC    = 40'(SLP_SGN_MIN * 64'd60 * SLP_CLK_HZ);
  localparam logic [39:0]     SLP_STRETCH_CYC = 40'(SLP_STRETCH_MS * (SLP_CLK_HZ / 64'd1000));
  localparam logic [39:0]     SLP_RETRY_CYC  = 40'(SLP_RETRY_S * SLP_CLK_HZ);

  // register byte offsets
  localparam logic [3:0]      SLP_OFS_CTRL   = 4'h0;
  localparam logic [3:0]      SLP_OFS_ID     = 4'h4;
  localparam logic [3:0]      SLP_OFS_STATUS = 4'h8;

  // control field positions and reset values
  localparam int              SLP_CTRL_LINK  = 0;
  localparam int              SLP_CTRL_MODE  = 1;
  localparam logic [7:0]      SLP_ID_RST     = 8'h01;

  // status field positions
  localparam int              SLP_ST_REG     = 0;
  localparam int              SLP_ST_NET     = 1;
  localparam int              SLP_ST_PKT     = 2;
  localparam int              SLP_ST_LVL     = 3;

  // cellular link mode
  typedef enum logic {
    SLP_LINK_TEXT   = 1'b0,
    SLP_LINK_PACKET = 1'b1
  } slp_link_t;

  // secondary serial port protocol mode
  typedef enum logic [2:0] {
    SLP_PM_RTU_MASTER  = 3'b000,
    SLP_PM_RTU_SLAVE   = 3'b001,
    SLP_PM_RTU_MIRROR  = 3'b010,
    SLP_PM_TRANSPARENT = 3'b011,
    SLP_PM_NAV_RX      = 3'b100,
    SLP_PM_MODEM       = 3'b101,
    SLP_PM_METER       = 3'b110,
    SLP_PM_CUSTOM      = 3'b111
  } slp_port_mode_t;

  // all state of the indicator top
  typedef struct packed {
    logic                  reg_q;      // registration seen last cycle
    logic                  blink;      // blink phase
    logic [SLP_CW-1:0]     blink_cnt;  // blink half-period counter
    logic                  net_led;
    logic                  pkt_led;
    logic [2:0]            level;      // signal bar leds
    logic [SLP_CW-1:0]     sgn_cnt;    // periodic refresh counter
    logic [SLP_CW-1:0]     retry_cnt;  // unregistered time counter
    logic                  modem_rst;  // retry reset pulse
    logic                  fwd;        // forward query pulse
    logic                  ser_valid;  // transparent byte out
    logic [7:0]            ser_data;
    slp_link_t             link;
    slp_port_mode_t        pmode;
    logic [7:0]            own_id;
    logic                  waitreq;
    logic [31:0]           rdata;
  } slp_st_t;

  // state of one flash stretcher
  typedef struct packed {
    logic [SLP_CW-1:0]     cnt;
    logic                  led;
  } slp_str_st_t;

  // level code 0..3 to bar pattern
  function automatic logic [2:0] slp_bars(input logic [1:0] lvl);
    slp_bars = (lvl == 2'h3) ? 3'h7 : (lvl == 2'h2) ? 3'h3 : (lvl == 2'h1) ? 3'h1 : 3'h0;
  endfunction

endpackage

/* File: core/slp_stretch.sv */
// activity flash stretcher for one led
`timescale 1ns/1ps
`default_nettype none
module slp_stretch #(
  parameter logic [39:0] HOLD = slp_pkg::SLP_STRETCH_CYC  // flash length in cycles
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // event in, led out
  input  wire logic trig,
  output logic      led
);

  slp_pkg::slp_str_st_t st_q;   // registered state
  slp_pkg::slp_str_st_t st_d;   // next state

  // retrigger restarts the full hold, so bursts read as one long flash
  always_comb begin
    st_d = st_q;
    if (trig) begin
      st_d.cnt = HOLD - 40'h1;
      st_d.led = 1'b1;
    end else if (st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - 40'h1;
    end else begin
      st_d.led = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign led = st_q.led;

  // flash ends exactly when the hold runs out
  chk_flash_end: assert property (@(posedge clk) disable iff (!nrst)
    (st_q.led && st_q.cnt == '0 && !trig) |=> !led)
    else $error("flash outlived its hold");

endmodule
`default_nettype wire

/* File: core/slp_top.sv */
// status led indicator: network, session, activity and signal bar leds
`timescale 1ns/1ps
`default_nettype none
module slp_top #(
  parameter logic [39:0] BLINK_CYC   = slp_pkg::SLP_BLINK_CYC,   // blink half period
  parameter logic [39:0] SGN_CYC     = slp_pkg::SLP_SGN_CYC,     // level refresh period
  parameter logic [39:0] STRETCH_CYC = slp_pkg::SLP_STRETCH_CYC, // flash length
  parameter logic [39:0] RETRY_CYC   = slp_pkg::SLP_RETRY_CYC    // registration retry time
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // modem status
  input  wire logic        net_registered,
  input  wire logic        apn_attached,
  input  wire logic [1:0]  sig_level,
  // cellular traffic events
  input  wire logic        tx_frame_evt,
  input  wire logic        tx_msg_evt,
  input  wire logic        rx_frame_evt,
  input  wire logic        rx_msg_evt,
  // secondary serial port events
  input  wire logic        port_tx_evt,
  input  wire logic        port_rx_evt,
  input  wire logic        query_evt,
  input  wire logic [7:0]  query_id,
  input  wire logic        pkt_rx_valid,
  input  wire logic [7:0]  pkt_rx_data,
  // leds
  output logic             net_led,
  output logic             pkt_sess_led,
  output logic             cell_tx_led,
  output logic             cell_rx_led,
  output logic [2:0]       level_leds,
  output logic             port_tx_led,
  output logic             port_rx_led,
  // actions towards modem and port
  output logic             modem_reset,
  output logic             query_fwd,
  output logic             ser_tx_valid,
  output logic [7:0]       ser_tx_data
);

  slp_pkg::slp_st_t st_q;        // registered state
  slp_pkg::slp_st_t st_d;        // next state
  logic             reg_rise;    // registration just gained
  logic             fwd_hit;     // slave query for another station
  logic             pass_hit;    // transparent byte to forward
  logic             cell_tx_trig;
  logic             cell_rx_trig;
  logic             port_tx_trig;
  logic             port_rx_trig;
  logic             bus_wr;      // write takes effect this edge
  logic             bus_rd;      // read data latched this edge

  // event decode, all combinational from inputs and registered state
  always_comb begin
    reg_rise     = net_registered && !st_q.reg_q;
    fwd_hit      = query_evt && (st_q.pmode == slp_pkg::SLP_PM_RTU_SLAVE)
                   && (query_id != st_q.own_id);
    pass_hit     = pkt_rx_valid && (st_q.pmode == slp_pkg::SLP_PM_TRANSPARENT);
    cell_tx_trig = tx_frame_evt || tx_msg_evt;
    cell_rx_trig = rx_frame_evt || rx_msg_evt;
    port_tx_trig = (st_q.pmode != slp_pkg::SLP_PM_NAV_RX) && (fwd_hit || pass_hit
                   || (port_tx_evt && st_q.pmode != slp_pkg::SLP_PM_RTU_SLAVE));
    port_rx_trig = port_rx_evt;
    // byte lanes 3:1 hold no fields, so only lane 0 gates a write
    // one wait state: access completes when waitrequest is low
    bus_wr       = avs_write && !st_q.waitreq;
    bus_rd       = avs_read && st_q.waitreq;
  end

  // next state of the whole block
  always_comb begin
    st_d       = st_q;
    st_d.reg_q = net_registered;

    // blink phase runs only while registered
    if (!net_registered) begin
      st_d.blink_cnt = '0;
      st_d.blink     = 1'b1;
    end else if (st_q.blink_cnt >= BLINK_CYC - 40'h1) begin
      st_d.blink_cnt = '0;
      st_d.blink     = !st_q.blink;
    end else begin
      st_d.blink_cnt = st_q.blink_cnt + 40'h1;
    end

    st_d.net_led = net_registered ? st_q.blink : 1'b1;
    st_d.pkt_led = apn_attached;

    // signal level sampling
    if (reg_rise) begin
      st_d.level   = slp_pkg::slp_bars(sig_level);
      st_d.sgn_cnt = '0;
    end else if (net_registered && st_q.link == slp_pkg::SLP_LINK_TEXT) begin
      if (st_q.sgn_cnt >= SGN_CYC - 40'h1) begin
        st_d.level   = slp_pkg::slp_bars(sig_level);
        st_d.sgn_cnt = '0;
      end else begin
        st_d.sgn_cnt = st_q.sgn_cnt + 40'h1;
      end
    end else begin
      st_d.sgn_cnt = '0;
    end

    st_d.modem_rst = 1'b0;
    if (net_registered) begin
      st_d.retry_cnt = '0;
    end else if (st_q.retry_cnt >= RETRY_CYC - 40'h1) begin
      st_d.retry_cnt = '0;
      st_d.modem_rst = 1'b1;
    end else begin
      st_d.retry_cnt = st_q.retry_cnt + 40'h1;
    end

    st_d.fwd       = fwd_hit;
    st_d.ser_valid = pass_hit;
    if (pass_hit) begin
      st_d.ser_data = pkt_rx_data;
    end

    // register writes, only lane 0 holds fields
    if (bus_wr && avs_byteenable[0]) begin
      unique case (avs_address)
        slp_pkg::SLP_OFS_CTRL: begin
          st_d.link  = slp_pkg::slp_link_t'(avs_writedata[slp_pkg::SLP_CTRL_LINK]);
          st_d.pmode = slp_pkg::slp_port_mode_t'(
                         avs_writedata[slp_pkg::SLP_CTRL_MODE +: 3]);
        end
        slp_pkg::SLP_OFS_ID: begin
          st_d.own_id = avs_writedata[7:0];
        end
        default: begin
          // status is read only, unmapped writes are dropped
        end
      endcase
    end

    // read data latched in the wait cycle, held through the answer
    if (bus_rd) begin
      st_d.rdata = '0;
      unique case (avs_address)
        slp_pkg::SLP_OFS_CTRL: begin
          st_d.rdata[slp_pkg::SLP_CTRL_LINK]     = st_q.link;
          st_d.rdata[slp_pkg::SLP_CTRL_MODE +: 3] = st_q.pmode;
        end
        slp_pkg::SLP_OFS_ID: begin
          st_d.rdata[7:0] = st_q.own_id;
        end
        slp_pkg::SLP_OFS_STATUS: begin
          st_d.rdata[slp_pkg::SLP_ST_REG]     = st_q.reg_q;
          st_d.rdata[slp_pkg::SLP_ST_NET]     = st_q.net_led;
          st_d.rdata[slp_pkg::SLP_ST_PKT]     = st_q.pkt_led;
          st_d.rdata[slp_pkg::SLP_ST_LVL +: 3] = st_q.level;
        end
        default: begin
          // unmapped reads return zero
        end
      endcase
    end

    // waitrequest drops for exactly one cycle per access
    st_d.waitreq = !((avs_read || avs_write) && st_q.waitreq);
  end

  // state register
  // reset: network led lit as unregistered, bus stalled, default station id
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q         <= '0;
      st_q.net_led <= 1'b1;
      st_q.blink   <= 1'b1;
      st_q.own_id  <= slp_pkg::SLP_ID_RST;
      st_q.waitreq <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from state flops
  assign net_led         = st_q.net_led;
  assign pkt_sess_led    = st_q.pkt_led;
  assign level_leds      = st_q.level;
  assign modem_reset     = st_q.modem_rst;
  assign query_fwd       = st_q.fwd;
  assign ser_tx_valid    = st_q.ser_valid;
  assign ser_tx_data     = st_q.ser_data;
  assign avs_readdata    = st_q.rdata;
  assign avs_waitrequest = st_q.waitreq;

  slp_stretch #(.HOLD(STRETCH_CYC)) u_cell_tx (
    .clk  (clk),
    .nrst (nrst),
    .trig (cell_tx_trig),
    .led  (cell_tx_led)
  );
  slp_stretch #(.HOLD(STRETCH_CYC)) u_cell_rx (
    .clk  (clk),
    .nrst (nrst),
    .trig (cell_rx_trig),
    .led  (cell_rx_led)
  );
  slp_stretch #(.HOLD(STRETCH_CYC)) u_port_tx (
    .clk  (clk),
    .nrst (nrst),
    .trig (port_tx_trig),
    .led  (port_tx_led)
  );
  slp_stretch #(.HOLD(STRETCH_CYC)) u_port_rx (
    .clk  (clk),
    .nrst (nrst),
    .trig (port_rx_trig),
    .led  (port_rx_led)
  );

  // checks on what the block drives
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_unreg_steady: assert property (!net_registered |=> net_led)
    else $error("network led not steady while unregistered");
  chk_reg_blink: assert property (
    (net_registered && $past(net_registered)) |=> net_led == $past(st_q.blink))
    else $error("network led does not follow blink phase");
  chk_apn_led: assert property (1'b1 |=> pkt_sess_led == $past(apn_attached))
    else $error("session led differs from attach state");
  chk_cell_tx_flash: assert property ((tx_frame_evt || tx_msg_evt) |=> cell_tx_led)
    else $error("cellular tx led missed an event");
  chk_cell_rx_flash: assert property ((rx_frame_evt || rx_msg_evt) |=> cell_rx_led)
    else $error("cellular rx led missed an event");
  chk_level_sample: assert property (
    $rose(net_registered) |=> level_leds == slp_pkg::slp_bars($past(sig_level)))
    else $error("level not sampled at registration");
  chk_packet_no_refresh: assert property (
    (st_q.link == slp_pkg::SLP_LINK_PACKET && net_registered && st_q.reg_q)
    |=> $stable(level_leds))
    else $error("level refreshed in packet mode");
  // text mode refresh lands on the last count of the refresh counter
  chk_text_refresh: assert property (
    (st_q.link == slp_pkg::SLP_LINK_TEXT && net_registered && st_q.reg_q
     && st_q.sgn_cnt == SGN_CYC - 40'h1)
    |=> level_leds == slp_pkg::slp_bars($past(sig_level)))
    else $error("level not refreshed in text mode");
  chk_retry_unreg: assert property (modem_reset |-> !$past(net_registered))
    else $error("modem reset while registered");
  chk_port_rx_flash: assert property (port_rx_evt |=> port_rx_led)
    else $error("port rx led missed an event");
  chk_own_query_kept: assert property (
    (query_evt && st_q.pmode == slp_pkg::SLP_PM_RTU_SLAVE && query_id == st_q.own_id)
    |=> !query_fwd)
    else $error("own station query was forwarded");
  chk_transparent_pass: assert property (
    pass_hit |=> ser_tx_valid && ser_tx_data == $past(pkt_rx_data) && port_tx_led)
    else $error("transparent byte not passed");
  // navigation mode: a dark tx led stays dark whatever the port reports
  chk_nav_no_tx: assert property (
    (st_q.pmode == slp_pkg::SLP_PM_NAV_RX && !port_tx_led) |=> !port_tx_led)
    else $error("port tx flashed in navigation mode");
  // slave mode: plain port sends do not light tx, foreign queries go out
  chk_slave_tx_ignored: assert property (
    (st_q.pmode == slp_pkg::SLP_PM_RTU_SLAVE && port_tx_evt && !fwd_hit && !port_tx_led)
    |=> !port_tx_led)
    else $error("port tx flashed for a send in slave mode");
  chk_fwd_foreign: assert property (fwd_hit |=> query_fwd && port_tx_led)
    else $error("foreign station query not forwarded");
  // packet data leaves the port only in transparent mode
  chk_pass_mode_only: assert property (
    (st_q.pmode != slp_pkg::SLP_PM_TRANSPARENT) |=> !ser_tx_valid)
    else $error("packet byte passed outside transparent mode");
  chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("bus access not answered in one wait state");

  cov_registration: cover property ($rose(net_registered));
  cov_forward: cover property (query_fwd);
  cov_transparent: cover property (ser_tx_valid);
  cov_retry: cover property (modem_reset);
  cov_nav_rx: cover property (st_q.pmode == slp_pkg::SLP_PM_NAV_RX && port_rx_led);

endmodule
`default_nettype wire

/* File: bench/slp_top_tb.sv */
// self-checking testbench for the status led indicator top
`timescale 1ns/1ps
`default_nettype none
module slp_top_tb;
  // one comparison, counted; a mismatch is reported at once
  `define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end

  logic        clk;             // system clock
  logic        nrst;            // async reset, active low
  logic [3:0]  avs_address;     // register bus request side
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;    // register bus answer side
  logic        avs_waitrequest;
  logic        net_registered;  // modem status levels
  logic        apn_attached;
  logic [1:0]  sig_level;
  logic [7:0]  ev;              // event pulses, one bit per source
  logic [7:0]  query_id;
  logic [7:0]  pkt_rx_data;
  logic        net_led;         // observed outputs
  logic        pkt_sess_led;
  logic        cell_tx_led;
  logic        cell_rx_led;
  logic [2:0]  level_leds;
  logic        port_tx_led;
  logic        port_rx_led;
  logic        modem_reset;
  logic        query_fwd;
  logic        ser_tx_valid;
  logic [7:0]  ser_tx_data;
  logic [6:0]  obs;             // one-bit outputs gathered for the flash watcher
  int          fails;
  int          samples_checked;
  int          cyc;
  logic [31:0] rd;

  assign obs = {ser_tx_valid, query_fwd, modem_reset, port_rx_led, port_tx_led,
                cell_rx_led, cell_tx_led};

  // short counts keep the run small; expectations below follow from them
  slp_top #(.BLINK_CYC(40'd4), .SGN_CYC(40'd50), .STRETCH_CYC(40'd3), .RETRY_CYC(40'd40)) dut_u (
    .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .net_registered(net_registered), .apn_attached(apn_attached), .sig_level(sig_level),
    .tx_frame_evt(ev[0]), .tx_msg_evt(ev[1]), .rx_frame_evt(ev[2]), .rx_msg_evt(ev[3]),
    .port_tx_evt(ev[4]), .port_rx_evt(ev[5]), .query_evt(ev[6]), .query_id(query_id),
    .pkt_rx_valid(ev[7]), .pkt_rx_data(pkt_rx_data), .net_led(net_led),
    .pkt_sess_led(pkt_sess_led), .cell_tx_led(cell_tx_led), .cell_rx_led(cell_rx_led),
    .level_leds(level_leds), .port_tx_led(port_tx_led), .port_rx_led(port_rx_led),
    .modem_reset(modem_reset), .query_fwd(query_fwd), .ser_tx_valid(ser_tx_valid),
    .ser_tx_data(ser_tx_data));

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      conclude();
    end
  end

  // verdict and end of run
  task automatic conclude();
    $display("checked %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // one avalon access; waits for waitrequest low under a bound, never assumes latency
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address    <= a;
    avs_write      <= w;
    avs_read       <= ~w;
    avs_writedata  <= d;
    avs_byteenable <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) fails++;
  endtask

  // pulse event e for one cycle, then count cycles output o is high over 8 cycles
  task automatic flash(input int e, input int o, input int expv);
    int c;
    c = 0;
    @(posedge clk);
    ev[e] <= 1'b1;
    @(posedge clk);
    ev[e] <= 1'b0;
    repeat (8) begin
      #1;
      if (obs[o] === 1'b1) c++;
      @(posedge clk);
    end
    `CHK(c, expv)
  endtask

  // port protocol mode lives in control bits 3:1, link mode in bit 0
  task automatic set_ctrl(input logic lnk, input logic [2:0] pm);
    bus(1'b1, 4'h0, {28'h0, pm, lnk}, rd);
  endtask

  // reset values and register defaults
  task automatic t_reset();
    #1;
    `CHK(net_led, 1'b1)
    `CHK(level_leds, 3'h0)
    `CHK(obs, 7'h00)
    bus(1'b0, 4'h4, 32'h0, rd);
    `CHK(rd, 32'h0000_0001)
    bus(1'b0, 4'hc, 32'h0, rd);
    `CHK(rd, 32'h0000_0000)
    bus(1'b0, 4'h8, 32'h0, rd);
    `CHK(rd, 32'h0000_0002)
    $display("test reset done");
  endtask

  // unregistered: led steady, modem reset pulsed once per retry period
  task automatic t_retry();
    int r;
    int l;
    r = 0;
    l = 0;
    repeat (45) begin
      @(posedge clk);
      #1;
      if (modem_reset === 1'b1) r++;
      if (net_led === 1'b1) l++;
    end
    `CHK(r, 1)
    `CHK(l, 45)
    $display("test retry done");
  endtask

  // text mode: level at registration, blink, periodic refresh
  task automatic t_text();
    int t;
    logic p;
    t = 0;
    @(posedge clk);
    sig_level      <= 2'h2;
    net_registered <= 1'b1;
    @(posedge clk);
    #1;
    `CHK(level_leds, 3'h3)
    p = net_led;
    repeat (16) begin
      @(posedge clk);
      #1;
      if (net_led !== p) t++;
      p = net_led;
    end
    `CHK(t, 4)
    @(posedge clk);
    sig_level <= 2'h3;
    repeat (54) @(posedge clk);
    #1;
    `CHK(level_leds, 3'h7)
    $display("test text mode done");
  endtask

  // packet mode: level taken only at registration
  task automatic t_packet();
    set_ctrl(1'b1, 3'h0);
    net_registered <= 1'b0;
    repeat (3) @(posedge clk);
    sig_level      <= 2'h1;
    net_registered <= 1'b1;
    @(posedge clk);
    #1;
    `CHK(level_leds, 3'h1)
    @(posedge clk);
    sig_level <= 2'h3;
    repeat (59) @(posedge clk);
    #1;
    `CHK(level_leds, 3'h1)
    $display("test packet mode done");
  endtask

  // session led follows attach one cycle later
  task automatic t_session();
    @(posedge clk);
    apn_attached <= 1'b1;
    @(posedge clk);
    apn_attached <= 1'b0;
    #1;
    `CHK(pkt_sess_led, 1'b1)
    @(posedge clk);
    #1;
    `CHK(pkt_sess_led, 1'b0)
    $display("test session done");
  endtask

  // cellular activity flashes, stretched and kept apart
  task automatic t_cell();
    flash(0, 0, 3);
    flash(1, 0, 3);
    flash(2, 1, 3);
    flash(3, 1, 3);
    flash(0, 1, 0);
    $display("test cellular activity done");
  endtask

  // secondary port activity across protocol modes
  task automatic t_port();
    set_ctrl(1'b0, 3'h0);
    flash(4, 2, 3);
    flash(5, 3, 3);
    flash(7, 6, 0);
    set_ctrl(1'b0, 3'h4);
    flash(4, 2, 0);
    flash(5, 3, 3);
    set_ctrl(1'b0, 3'h1);
    flash(4, 2, 0);
    query_id <= 8'h01;
    flash(6, 5, 0);
    query_id <= 8'h22;
    flash(6, 5, 1);
    flash(6, 2, 3);
    set_ctrl(1'b0, 3'h3);
    bus(1'b0, 4'h0, 32'h0, rd);
    `CHK(rd, 32'h0000_0006)
    pkt_rx_data <= 8'ha5;
    flash(7, 6, 1);
    `CHK(ser_tx_data, 8'ha5)
    $display("test port modes done");
  endtask

  // main sequence
  initial begin
    nrst = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    net_registered = 1'b0;
    apn_attached = 1'b0;
    sig_level = 2'h0;
    ev = 8'h00;
    query_id = 8'h00;
    pkt_rx_data = 8'h00;
    fails = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_retry();
    t_text();
    t_packet();
    t_session();
    t_cell();
    t_port();
    conclude();
  end
endmodule
`default_nettype wire
